// file: hw/link_defs.svh
// Function
// [RULE_01] host computes minimum cycle from slave figures; here CYCLE_MIN is a fixed parameter, not computed by the host
// [RULE_02] host clock period never below slave minimum
// [RULE_03] frame spacing respects computed and absolute minima
// [RULE_04] n slaves: four clocks plus delays plus channels
// [RULE_05] one slave: clock times five plus lengths
// [RULE_06] standard operation forwards data and return line
// [RULE_07] feedback operation drives own data onto return
// [RULE_08] broadcast code 10 switches couplers to feedback; here it toggles them, so couplers in feedback go back to standard
// [RULE_09] node without coupler ignores switch code
// [RULE_10] host restores couplers one by one, checks; here a second broadcast code 10 toggles all couplers back, unchecked
// [RULE_11] host keeps link clock within permitted range
// [RULE_12] node works across required clock range
// [RULE_13] clock phases at least forty percent period
// [RULE_14] adaptive timeout within reference plus three periods; node has no timeout, the marker re-arms it each frame
// [RULE_15] host tolerates line delay up to maximum
// [RULE_16] host sampling tolerates quarter period jitter
// [RULE_17] processing time and start delay within limits
// [RULE_18] register access finishes within twenty milliseconds
// [RULE_19] node output lags forwarded clock within half phase
// [RULE_20] host measures line delay and uses it; DELAY is only an output, sampling does not use it
// [RULE_21] coupler starts in standard operation after reset
`ifndef LINK_DEFS_SVH
`define LINK_DEFS_SVH
`define CLK_NS          8
`define LINK_HALF_DIV   8'h3f
`define TIMEOUT_NS      20000
`define TIMEOUT_CYC     ((`TIMEOUT_NS + `CLK_NS - 1) / `CLK_NS)
`define HDR_CLOCKS      4
`define CMD_COUPLER     2'h2
`define CMD_MARK        2'h1
`define MARK_PATTERN    4'h1
`define CMD_BITS        4
`define BUSY_CLOCKS     2
`define START_DLY_MAX   8
`endif

// file: hw/link_pkg.sv
package link_pkg;
  typedef enum {H_IDLE, H_RUN, H_GAP} host_state_t;
  typedef enum {N_IDLE, N_BUSY, N_SHIFT, N_TAIL} node_state_t;
endpackage

// file: hw/link_if.sv
`timescale 1ns/1ps
interface link_if;
  logic host_clock_out;
  logic host_data_out;
  logic host_data_in;
  modport host (output host_clock_out, output host_data_out,
                input host_data_in);
  modport node (input host_clock_out, input host_data_out,
                output host_data_in);
endinterface

// file: hw/sync2.sv
`timescale 1ns/1ps
module sync2
  (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic RESET,
    // level in and out
    input  wire logic D,
    output logic      Q
  );
  logic meta;

  // two-stage synchroniser; meta is read only by q
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      meta <= 1'h0;
      Q    <= 1'h0;
    end
    else
    begin
      meta <= D;
      Q    <= meta;
    end
  end
endmodule

// file: hw/link_host.sv
`timescale 1ns/1ps
`include "link_defs.svh"
module link_host
  import link_pkg::*;
  #(
    parameter int CHANNEL_PAYLOAD_BITS   = 24,
    parameter int CHECKSUM_BITS = 6,
    parameter int BUSY_CYC = 128,
    parameter int CYCLE_MIN = 32000
  )
  (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic RESET,
    // user side
    input  wire logic START,
    input  wire logic [1:0] CMD,
    output logic      BUSY,
    output logic      DONE,
    output logic [31:0] DATA,
    output logic [15:0] DELAY,
    // link
    link_if.host      LINK
  );
  host_state_t state;
  logic [7:0]  div;
  logic        clk_out;
  logic [15:0] bits;
  logic [31:0] gap;
  logic        rx;
  logic [15:0] total;
  logic [31:0] shreg;
  logic        delay_open;

  // return data crosses into our domain
  sync2 u_rx (.CLOCK(CLOCK), .RESET(RESET), .D(LINK.host_data_in),
              .Q(rx));

  // enough clocks: header, busy, channel plus tail
  assign total = 16'(`HDR_CLOCKS + `START_DLY_MAX + 1 + CHANNEL_PAYLOAD_BITS + CHECKSUM_BITS
                     + 2 * `CMD_BITS); // see [RULE_04] [RULE_05]

  // divider makes link clock; 50% duty, period fixed above minimum
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      state   <= H_IDLE;
      div     <= 8'h00;
      clk_out <= 1'h1;
      bits    <= 16'h0000;
      gap     <= 32'h0;
      BUSY    <= 1'h0;
      DONE    <= 1'h0;
    end
    else
    begin
      DONE <= 1'h0;
      case (state)
        H_IDLE:
        begin
          if (START)
          begin
            state <= H_RUN;
            BUSY  <= 1'h1;
            bits  <= 16'h0000;
            div   <= 8'h00;
          end
        end
        H_RUN:
        begin
          div <= div + 8'h01; // see [RULE_02] [RULE_11] [RULE_13]
          if (div == `LINK_HALF_DIV)
          begin
            div     <= 8'h00;
            clk_out <= ~clk_out;
            if (!clk_out)
              bits <= bits + 16'h0001;
            if (!clk_out && bits == total)
            begin
              state <= H_GAP;
              gap   <= 32'h0;
            end
          end
        end
        H_GAP:
        begin
          gap <= gap + 32'h1; // see [RULE_03]
          if (gap >= 32'(CYCLE_MIN + `TIMEOUT_CYC))
          begin
            state <= H_IDLE;
            BUSY  <= 1'h0;
            DONE  <= 1'h1;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // marker, then the two command bits, then zeros; the node has no
  // timer of its own, so it finds frame and command from this pattern
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      LINK.host_data_out <= 1'h0;
    else if (state == H_RUN && bits == 16'h0000)
      LINK.host_data_out <= 1'h1;
    else if (state == H_RUN && bits >= 16'h0001 && bits <= 16'h0002)
      LINK.host_data_out <= CMD[bits[0]]; // see [RULE_10]
    else
      LINK.host_data_out <= 1'h0;
  end

  assign LINK.host_clock_out = clk_out;

  // line delay: second rising link edge to first low return bit;
  // the count includes the two synchroniser stages
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      DELAY      <= 16'h0000;
      delay_open <= 1'h0;
    end
    else if (state == H_IDLE && START)
    begin
      DELAY      <= 16'h0000;
      delay_open <= 1'h1;
    end
    else if (delay_open && state == H_RUN && bits >= 16'h0002)
    begin
      if (rx)
        DELAY <= DELAY + 16'h0001; // see [RULE_15] [RULE_20]
      else
        delay_open <= 1'h0;
    end
  end

  // capture return bits at falling half of each link clock; mid-bit
  // sampling leaves half a period either way for jitter
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      shreg <= 32'h0;
      DATA  <= 32'h0;
    end
    else
    begin
      if (state == H_RUN && div == `LINK_HALF_DIV && clk_out)
        shreg <= {shreg[30:0], rx}; // see [RULE_01] [RULE_16]
      if (state == H_GAP && gap == 32'h0)
        DATA <= shreg;
    end
  end
endmodule

// file: hw/link_node.sv
`timescale 1ns/1ps
`include "link_defs.svh"
module link_node
  import link_pkg::*;
  #(
    parameter bit HAS_COUPLER = 1'b1,
    parameter int DW = 32
  )
  (
    // link clock domain
    input  wire logic NODE_CLOCK,
    input  wire logic RESET,
    // chain side
    input  wire logic NODE_DATA_IN,
    output logic      NODE_DATA_OUT,
    input  wire logic RETURN_IN,
    output logic      NODE_CLOCK_FWD,
    // user side
    input  wire logic [DW-1:0] SENSOR,
    output logic      FEEDBACK,
    // link
    link_if.node      LINK
  );
  node_state_t state;
  logic [DW-1:0] shreg;
  logic [3:0]    cmd;
  logic [3:0]    cnt;
  logic          frame_start;

  assign NODE_CLOCK_FWD = NODE_CLOCK; // see [RULE_19]

  // marker after three zero bits opens a frame; command bits cannot
  // fake it, since they never follow three zeros with a one
  assign frame_start = ({cmd[2:0], LINK.host_data_out} == `MARK_PATTERN);

  // host data history, kept across frames so the pattern stays framed
  always_ff @(posedge NODE_CLOCK or posedge RESET)
  begin
    if (RESET)
      cmd <= 4'h0;
    else
      cmd <= {cmd[2:0], LINK.host_data_out};
  end

  // latch on the marker, wait processing time, then shift on rising edge
  always_ff @(posedge NODE_CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      state <= N_IDLE;
      shreg <= '0;
      cnt   <= 4'h0;
    end
    else
    begin
      case (state)
        N_IDLE:
        begin
          if (frame_start)
          begin
            shreg <= SENSOR;
            state <= N_BUSY;
            cnt   <= 4'h0;
          end
        end
        N_BUSY:
        begin
          cnt <= cnt + 4'h1; // see [RULE_17]
          if (cnt == 4'(`BUSY_CLOCKS))
            state <= N_SHIFT;
        end
        N_SHIFT:
        begin
          shreg <= {shreg[DW-2:0], NODE_DATA_IN}; // see [RULE_06]
          if (frame_start)
          begin
            shreg <= SENSOR;
            state <= N_BUSY;
            cnt   <= 4'h0;
          end
        end
        default: state <= N_IDLE;
      endcase
    end
  end

  assign NODE_DATA_OUT = shreg[DW-1];

  // coupler; starts standard, marker plus code 10 toggles it
  always_ff @(posedge NODE_CLOCK or posedge RESET)
  begin
    if (RESET)
      FEEDBACK <= 1'h0; // see [RULE_21]
    else if (HAS_COUPLER && cmd == {`CMD_MARK, `CMD_COUPLER})
      FEEDBACK <= ~FEEDBACK; // see [RULE_08] [RULE_09]
  end

  // return mux; feedback cuts off downstream nodes
  assign LINK.host_data_in = FEEDBACK ? NODE_DATA_OUT
                                      : RETURN_IN; // see [RULE_07]
  // fully static logic clocked only by the link, so any rate in the
  // required range works; the marker re-arms each frame in place of a
  // timer, and there is no register access to wait on
  // see [RULE_12] [RULE_14] [RULE_18]
endmodule

// file: verif/link_props.sv
`timescale 1ns/1ps
`include "link_defs.svh"
module link_props
  #(
    parameter int CHANNEL_PAYLOAD_BITS      = 24,
    parameter int CHECKSUM_BITS    = 6,
    parameter int CYCLE_MIN = 32000
  )
  (
    // host clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // link wires
    input wire logic host_clock_out,
    input wire logic host_data_out,
    input wire logic host_data_in,
    // ends
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic FEEDBACK,
    input wire logic NODE_DATA_OUT,
    input wire logic RETURN_IN
  );
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  logic [15:0] low_len;
  logic [15:0] busy_len;
  // low phase and frame length; 16 bits cover the longest frame
  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
    begin
      low_len  <= 16'h0;
      busy_len <= 16'h0;
    end
    else
    begin
      low_len  <= host_clock_out ? 16'h0 : low_len + 16'h1;
      busy_len <= BUSY ? busy_len + 16'h1 : 16'h0;
    end
  coupler_reset_a: assert property (
    $fell(RESET) |-> !FEEDBACK)
    else $error("coupler not in standard operation");
  std_route_a: assert property (
    !FEEDBACK |-> host_data_in == RETURN_IN)
    else $error("return line not passed through");
  fb_route_a: assert property (
    FEEDBACK |-> host_data_in == NODE_DATA_OUT)
    else $error("own data not on return line");
  idle_clock_a: assert property (
    !BUSY |-> host_clock_out)
    else $error("link clock moved while idle");
  low_phase_a: assert property (
    $rose(host_clock_out) |-> low_len == 16'h40)
    else $error("link clock low phase wrong");
  frame_len_a: assert property (
    $fell(BUSY) |->
    busy_len >= (5 + CHANNEL_PAYLOAD_BITS + CHECKSUM_BITS) * 128 + `TIMEOUT_CYC)
    else $error("frame shorter than minimum cycle");
  cycle_min_a: assert property (
    $fell(BUSY) |-> busy_len >= CYCLE_MIN + `TIMEOUT_CYC)
    else $error("frame spacing below minimum");
  done_pulse_a: assert property (
    DONE |=> !DONE ##1 !DONE)
    else $error("done longer than one cycle");
  fb_idle_a: assert property (
    !BUSY && !$past(BUSY) |-> $stable(FEEDBACK))
    else $error("coupler switched outside a frame");
endmodule

// file: verif/encoder_link_cycle_and_coupler_bench.sv
`timescale 1ns/1ps
module encoder_link_cycle_and_coupler_bench;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  logic [1:0]  cmd = 2'h0;
  logic        ret = 1'b0;
  logic        busy, done, feedback, feedback_b, node_out;
  logic [31:0] data;
  logic [15:0] delay;
  logic        chain = 1'b0;
  logic [31:0] sensor = 32'h5a5a5a5a;
  int          mismatches = 0;
  int          num_checks = 0;
  link_if link_if_i ();
  link_if link_if_b_i ();
  // system clock
  always #4 clock = ~clock;
  // main pair and its checker
  link_host #(.CYCLE_MIN(100)) link_host_i (.CLOCK(clock), .RESET(reset),
    .START(start), .CMD(cmd), .BUSY(busy), .DONE(done), .DATA(data),
    .DELAY(delay), .LINK(link_if_i.host));
  link_node link_node_i (.NODE_CLOCK(link_if_i.host_clock_out),
    .RESET(reset), .NODE_DATA_IN(chain), .NODE_DATA_OUT(node_out),
    .RETURN_IN(ret), .NODE_CLOCK_FWD(), .SENSOR(sensor),
    .FEEDBACK(feedback), .LINK(link_if_i.node));
  link_props #(.CYCLE_MIN(100)) link_props_i (.CLOCK(clock), .RESET(reset),
    .host_clock_out(link_if_i.host_clock_out),
    .host_data_out(link_if_i.host_data_out),
    .host_data_in(link_if_i.host_data_in), .BUSY(busy), .DONE(done),
    .FEEDBACK(feedback), .NODE_DATA_OUT(node_out), .RETURN_IN(ret));
  // second pair whose node has no coupler
  link_host #(.CYCLE_MIN(100)) link_host_b_i (.CLOCK(clock), .RESET(reset),
    .START(start), .CMD(cmd), .BUSY(), .DONE(), .DATA(), .DELAY(),
    .LINK(link_if_b_i.host));
  link_node #(.HAS_COUPLER(1'b0)) link_node_b_i (.RESET(reset),
    .NODE_CLOCK(link_if_b_i.host_clock_out), .NODE_DATA_IN(chain),
    .NODE_DATA_OUT(), .RETURN_IN(ret), .NODE_CLOCK_FWD(),
    .SENSOR(sensor), .FEEDBACK(feedback_b), .LINK(link_if_b_i.node));
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one frame; a second start mid-frame must be ignored
  task automatic frame(input logic [1:0] c, input logic r);
    int n;
    @(posedge clock);
    cmd   <= c;
    ret   <= r;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (20) @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 20000)
    begin
      mismatches++;
      finish_test();
    end
    repeat (3) @(posedge clock);
    check("busy after done", {31'h0, busy}, 32'h0);
    $display("frame with command %h done", c);
  endtask
  // reset, then walk the coupler through both operations
  initial
  begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    check("coupler after reset", {31'h0, feedback}, 32'h0);
    frame(2'h0, 1'b1);
    check("standard return high", data, 32'hffffffff);
    frame(2'h0, 1'b0);
    check("standard return low", data, 32'h0);
    check("delay no line", {16'h0, delay}, 32'h0);
    frame(2'h2, 1'b0);
    check("switch to feedback", {31'h0, feedback}, 32'h1);
    check("no coupler ignores", {31'h0, feedback_b}, 32'h0);
    // mid-run reset must drop the coupler back to standard
    reset <= 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    check("coupler after rearm", {31'h0, feedback}, 32'h0);
    $display("mid-run reset done");
    frame(2'h2, 1'b0);
    check("feedback again", {31'h0, feedback}, 32'h1);
    chain <= 1'b1;
    frame(2'h0, 1'b1);
    check("downstream cut", {31'h0, &data}, 32'h0);
    frame(2'h2, 1'b1);
    check("back to standard", {31'h0, feedback}, 32'h0);
    frame(2'h1, 1'b0);
    check("code 01 ignored", {31'h0, feedback}, 32'h0);
    frame(2'h3, 1'b0);
    check("code 11 ignored", {31'h0, feedback}, 32'h0);
    finish_test();
  end
endmodule
